// ==== rtl/hardware_limit_timer.sv ====
// hardware limit timer: 8-bit period timer with external reset modes
//
// Function
// R1 - software gate: count advances each timer clock while run bit set
// R2 - on count equal period, next timer clock loads zero and keeps counting
// R3 - hardware gate: counting also needs external level high or low per code
// R4 - edge limit modes reset count on any, rising or falling edge
// R5 - after an early edge reset counting restarts two timer clocks later
// R6 - level limit modes hold count in reset at low or high level
// R7 - level limit modes ignore external signal while run bit clear
// R8 - level reset takes two clocks; resume after match or two clocks after release
// R9 - one-shot edge modes start on first edge, reset on later same edges
// R10 - one-shot 110/111 start on an edge and reset on a level
// R11 - one-shot: period match clears run bit and stops count at zero
// R12 - monostable: period match stops count at zero, run bit stays set
// R13 - monostable starts on rising, falling or either edge with run bit set
// R14 - level one-shot holds reset at reset level, runs at opposite level
// R15 - edge-started modes need a fresh edge after run bit set again
// R16 - interrupt flag raised when postscaler count matches selected ratio
// R17 - interrupt forwarded only when interrupt enable bit set
// R18 - run bit and external reset are synchronised over two timer clocks; code syncs only the external reset, over three clock stages
// R19 - postscaler match gives one-clock pulse and clears postscaler count
// R20 - external source spaces edges six clocks, holds levels three clocks
// R21 - external triggers ignored during debug freeze
// R22 - software must not program reserved mode codes
// R23 - edges found by comparing synchronised signal with previous timer clock value
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

module hardware_limit_timer
  import hlt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire hlt_pkg::reg_req_t req,
  output logic [7:0]      rdata,
  // external reset source and debug
  input  wire logic       ext_reset_input,
  input  wire logic       debug_freeze,
  // outputs
  output logic            postscaled_match_pulse,
  output logic            timer_irq,
  output logic [7:0]      timer_count,
  output logic            period_match
);
  import hlt_pkg::*;

  hlt_state_t s_reg;
  hlt_state_t s_next;

  // prescaler ratio 1,2,4..128 as a terminal count
  function automatic logic [6:0] pre_limit(input logic [2:0] sel);
    pre_limit = 7'(({6'h0, 1'b1} << sel) - 7'h1);
  endfunction : pre_limit

  logic       tick;
  logic       match;
  logic       rise;
  logic       fall;
  logic       edge_any;
  logic       mode_edge;
  logic       start_edge;
  logic       lvl_reset;
  logic       oneshot;
  logic       mono;
  logic       gate_ok;

  always_comb
  begin
    tick  = (s_reg.pre_cnt == pre_limit(s_reg.prescale_select));
    match = (s_reg.timer_count == s_reg.period_value);
    // ext level accepted once second and third stages agree
    rise  = s_reg.ers_level & ~s_reg.ers_prev & ~debug_freeze; // R21 R23
    fall  = ~s_reg.ers_level & s_reg.ers_prev & ~debug_freeze; // R21 R23
    edge_any = rise | fall;
    oneshot = (s_reg.mode[4:3] == 2'b01) || (s_reg.mode == MODE_LOS_LOW)
           || (s_reg.mode == MODE_LOS_HIGH);
    mono    = (s_reg.mode == MODE_MS_RISE) || (s_reg.mode == MODE_MS_FALL)
           || (s_reg.mode == MODE_MS_ANY);
    mode_edge = 1'b0;
    start_edge = 1'b0;
    lvl_reset = 1'b0;
    gate_ok = 1'b1;
    case (s_reg.mode)
      MODE_GATE_HIGH:  gate_ok = s_reg.ers_level | debug_freeze; // R3
      MODE_GATE_LOW:   gate_ok = ~s_reg.ers_level | debug_freeze; // R3
      MODE_EDGE_ANY:   mode_edge = edge_any; // R4
      MODE_EDGE_RISE:  mode_edge = rise; // R4
      MODE_EDGE_FALL:  mode_edge = fall; // R4
      MODE_LVL_LOW:    lvl_reset = ~s_reg.ers_level & ~debug_freeze; // R6
      MODE_LVL_HIGH:   lvl_reset = s_reg.ers_level & ~debug_freeze; // R6
      MODE_OS_RISE, MODE_MS_RISE: start_edge = rise; // R13
      MODE_OS_FALL, MODE_MS_FALL: start_edge = fall; // R13
      MODE_OS_ANY, MODE_MS_ANY:   start_edge = edge_any; // R13
      MODE_OS_HL_RISE:
      begin
        start_edge = rise; // R9
        mode_edge  = rise; // R9
      end
      MODE_OS_HL_FALL:
      begin
        start_edge = fall; // R9
        mode_edge  = fall; // R9
      end
      MODE_OS_RL_LOW:
      begin
        start_edge = rise; // R10
        lvl_reset  = ~s_reg.ers_level & ~debug_freeze; // R10
      end
      MODE_OS_RL_HIGH:
      begin
        start_edge = fall; // R10
        lvl_reset  = s_reg.ers_level & ~debug_freeze; // R10
      end
      MODE_LOS_LOW:    lvl_reset = ~s_reg.ers_level & ~debug_freeze; // R14
      MODE_LOS_HIGH:   lvl_reset = s_reg.ers_level & ~debug_freeze; // R14
      default:         gate_ok = 1'b1;
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.postscaled_match_pulse = 1'b0;
    s_next.rdata = 8'h00;
    // three-stage sync; only stages 2 and 3 are compared
    s_next.ers_sync = {s_reg.ers_sync[1:0], ext_reset_input}; // R18
    if (s_reg.ers_sync[2] == s_reg.ers_sync[1])
      s_next.ers_level = s_reg.ers_sync[2];

    s_next.pre_cnt = tick ? 7'h00 : 7'(s_reg.pre_cnt + 7'h1);

    if (tick)
    begin
      s_next.ers_prev = s_reg.ers_level; // R23
      if (!s_reg.on)
      begin
        // losing the run bit drops any armed start
        s_next.state = ST_IDLE; // R15
      end
      else
      begin
        case (s_reg.state)
          ST_IDLE:
          begin
            // fresh start needs an edge in edge-started modes
            if (s_reg.mode == MODE_MS_RISE || s_reg.mode == MODE_MS_FALL
                || s_reg.mode == MODE_MS_ANY || (s_reg.mode[4:3] == 2'b01
                && s_reg.mode != MODE_OS_SW))
              s_next.state = ST_ARMED; // R15
            else
              s_next.state = ST_RUN;
          end
          ST_ARMED:
          begin
            if (start_edge)
            begin
              s_next.state = ST_HOLD; // R9 R13
              s_next.delay_cnt = RESTART_DELAY;
            end
          end
          ST_HOLD:
          begin
            s_next.timer_count = COUNT_RESET;
            if (lvl_reset)
              s_next.delay_cnt = RESTART_DELAY; // R8
            else if (s_reg.delay_cnt > 2'h1)
              s_next.delay_cnt = s_reg.delay_cnt - 2'h1; // R5
            else
              s_next.state = ST_RUN; // R5 R8
          end
          ST_RUN:
          begin
            if (mode_edge)
            begin
              s_next.timer_count = COUNT_RESET; // R4
              s_next.state = ST_HOLD;
              s_next.delay_cnt = RESTART_DELAY - 2'h1; // R5
            end
            else if (lvl_reset)
            begin
              s_next.timer_count = COUNT_RESET; // R6 R7 R14
              s_next.state = ST_HOLD;
              s_next.delay_cnt = RESTART_DELAY;
            end
            // a closed gate freezes the period reload as well as the count
            else if (match && gate_ok)
            begin
              s_next.timer_count = COUNT_RESET; // R2
              s_next.post_cnt = 4'(s_reg.post_cnt + 4'h1); // R19
              if (s_reg.post_cnt == s_reg.postscale_select)
              begin
                s_next.post_cnt = 4'h0; // R19
                s_next.postscaled_match_pulse = 1'b1; // R19
                s_next.irq_flag = 1'b1; // R16
              end
              if (oneshot)
              begin
                s_next.on = 1'b0; // R11
                s_next.state = ST_IDLE; // R11
              end
              else if (mono)
                s_next.state = ST_ARMED; // R12
            end
            else if (gate_ok)
              s_next.timer_count = 8'(s_reg.timer_count + 8'h1); // R1 R3
          end
          default: s_next.state = ST_IDLE;
        endcase
      end
    end

    // register writes; hardware set of flag wins over clear
    if (req.wr)
    begin
      case (req.addr)
        ADDR_CONTROL:
        begin
          s_next.on = req.wdata[CTRL_ON_BIT]; // R1
          s_next.prescale_select = req.wdata[CTRL_PRE_HI:CTRL_PRE_LO];
          s_next.postscale_select = req.wdata[CTRL_POST_HI:CTRL_POST_LO];
          s_next.pre_cnt = 7'h00;
          s_next.post_cnt = 4'h0;
        end
        ADDR_PERIOD: s_next.period_value = req.wdata;
        ADDR_COUNT:
        begin
          s_next.timer_count = req.wdata;
          s_next.pre_cnt = 7'h00;
          s_next.post_cnt = 4'h0;
        end
        ADDR_MODE:
        begin
          s_next.mode = req.wdata[4:0];
          s_next.state = ST_IDLE;
        end
        ADDR_IRQ_CTRL:
        begin
          s_next.timer_irq_enable = req.wdata[IRQ_EN_BIT];
          if (!req.wdata[IRQ_FLAG_BIT] && !s_next.irq_flag)
            s_next.irq_flag = 1'b0;
          else if (!req.wdata[IRQ_FLAG_BIT] && !(tick && s_next.postscaled_match_pulse))
            s_next.irq_flag = 1'b0;
        end
        default: s_next.timer_irq_enable = s_next.timer_irq_enable;
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        ADDR_CONTROL:  s_next.rdata = {s_reg.on, s_reg.prescale_select, s_reg.postscale_select};
        ADDR_PERIOD:   s_next.rdata = s_reg.period_value;
        ADDR_COUNT:    s_next.rdata = s_reg.timer_count;
        ADDR_MODE:     s_next.rdata = {3'h0, s_reg.mode};
        ADDR_IRQ_CTRL: s_next.rdata = {6'h00, s_reg.irq_flag, s_reg.timer_irq_enable};
        default:       s_next.rdata = 8'h00;
      endcase
    end
    s_next.irq = s_next.irq_flag & s_next.timer_irq_enable; // R17
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.period_value <= PERIOD_RESET;
      s_reg.state <= ST_IDLE;
    end
    else
      s_reg <= s_next;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      period_match <= 1'b0;
    else
      // only a match that really reloads the count, so the count reads zero beside it
      period_match <= tick & match & gate_ok & ~mode_edge & ~lvl_reset & s_reg.on
                      & (s_reg.state == ST_RUN) & ~(req.wr && req.addr == ADDR_COUNT); // R2
  end

  assign rdata = s_reg.rdata;
  assign postscaled_match_pulse = s_reg.postscaled_match_pulse;
  assign timer_irq = s_reg.irq;
  assign timer_count = s_reg.timer_count;

endmodule : hardware_limit_timer

// ==== inc/hlt_pkg.sv ====
// package: constants and types for the hardware limit timer
package hlt_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_PERIOD   = 4'h1;
  localparam logic [3:0] ADDR_COUNT    = 4'h2;
  localparam logic [3:0] ADDR_MODE     = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CTRL = 4'h4;

  // control register field positions
  localparam int CTRL_ON_BIT    = 7;
  localparam int CTRL_PRE_HI    = 6;
  localparam int CTRL_PRE_LO    = 4;
  localparam int CTRL_POST_HI   = 3;
  localparam int CTRL_POST_LO   = 0;
  // interrupt control register: enable bit 0, sticky flag bit 1
  localparam int IRQ_EN_BIT     = 0;
  localparam int IRQ_FLAG_BIT   = 1;

  // reset values
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [4:0] MODE_RESET   = 5'h00;

  // timing counts in timer clocks
  localparam int         SYNC_DELAY_TCLK    = 2;
  localparam logic [1:0] RESTART_DELAY      = 2'h2;

  // mode codes
  localparam logic [4:0] MODE_SW_GATE     = 5'h00;
  localparam logic [4:0] MODE_GATE_HIGH   = 5'h01;
  localparam logic [4:0] MODE_GATE_LOW    = 5'h02;
  localparam logic [4:0] MODE_EDGE_ANY    = 5'h03;
  localparam logic [4:0] MODE_EDGE_RISE   = 5'h04;
  localparam logic [4:0] MODE_EDGE_FALL   = 5'h05;
  localparam logic [4:0] MODE_LVL_LOW     = 5'h06;
  localparam logic [4:0] MODE_LVL_HIGH    = 5'h07;
  localparam logic [4:0] MODE_OS_SW       = 5'h08;
  localparam logic [4:0] MODE_OS_RISE     = 5'h09;
  localparam logic [4:0] MODE_OS_FALL     = 5'h0A;
  localparam logic [4:0] MODE_OS_ANY      = 5'h0B;
  localparam logic [4:0] MODE_OS_HL_RISE  = 5'h0C;
  localparam logic [4:0] MODE_OS_HL_FALL  = 5'h0D;
  localparam logic [4:0] MODE_OS_RL_LOW   = 5'h0E;
  localparam logic [4:0] MODE_OS_RL_HIGH  = 5'h0F;
  localparam logic [4:0] MODE_MS_RISE     = 5'h11;
  localparam logic [4:0] MODE_MS_FALL     = 5'h12;
  localparam logic [4:0] MODE_MS_ANY      = 5'h13;
  localparam logic [4:0] MODE_LOS_LOW     = 5'h16;
  localparam logic [4:0] MODE_LOS_HIGH    = 5'h17;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_HOLD} run_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       on;
    logic [2:0] prescale_select;
    logic [3:0] postscale_select;
    logic [7:0] period_value;
    logic [7:0] timer_count;
    logic [4:0] mode;
    logic       timer_irq_enable;
    logic       irq_flag;
    logic [6:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [2:0] ers_sync;
    logic       ers_level;
    logic       ers_prev;
    logic [1:0] delay_cnt;
    run_state_t state;
    logic       postscaled_match_pulse;
    logic       irq;
    logic [7:0] rdata;
  } hlt_state_t;

endpackage : hlt_pkg

// ==== testbench/hlt_monitor.sv ====
// concurrent checks on the hardware limit timer ports
`timescale 1ns/10ps
module hlt_monitor
  import hlt_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // register port
  input wire hlt_pkg::reg_req_t req,
  input wire logic [7:0]        rdata,
  // external side
  input wire logic              ext_reset_input,
  input wire logic              debug_freeze,
  // outputs
  input wire logic              postscaled_match_pulse,
  input wire logic              timer_irq,
  input wire logic [7:0]        timer_count,
  input wire logic              period_match
);
  import hlt_pkg::*;
  logic [4:0] mode_reg;
  logic       on_reg;
  logic       en_reg;
  logic [3:0] hi_cnt;
  logic [3:0] lo_cnt;
  logic       quiet;
  // writes and freeze restart the level counts, so a stale level never counts
  assign quiet = !req.wr && !debug_freeze;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_reg <= MODE_RESET;
      on_reg   <= 1'b0;
      en_reg   <= 1'b0;
      hi_cnt   <= 4'h0;
      lo_cnt   <= 4'h0;
    end
    else
    begin
      if (req.wr && req.addr == ADDR_MODE)
        mode_reg <= req.wdata[4:0];
      if (req.wr && req.addr == ADDR_CONTROL)
        on_reg <= req.wdata[CTRL_ON_BIT];
      if (req.wr && req.addr == ADDR_IRQ_CTRL)
        en_reg <= req.wdata[IRQ_EN_BIT];
      hi_cnt <= (quiet && ext_reset_input) ? hi_cnt + {3'h0, hi_cnt != 4'hF} : 4'h0;
      lo_cnt <= (quiet && !ext_reset_input) ? lo_cnt + {3'h0, lo_cnt != 4'hF} : 4'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  rd_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  count_step_a: assert property (!$past(req.wr) && timer_count != $past(timer_count)
    |-> timer_count == $past(timer_count) + 8'h01 || timer_count == 8'h00)
    else $error("count moved other than up by one or to zero");
  match_zero_a: assert property (period_match |-> timer_count == 8'h00)
    else $error("count not zero after period match");
  post_one_a: assert property (postscaled_match_pulse |=> !postscaled_match_pulse)
    else $error("postscaled pulse wider than one clock");
  post_cause_a: assert property (postscaled_match_pulse |-> period_match
    || $past(period_match) || $past(period_match, 2))
    else $error("postscaled pulse without period match");
  irq_gate_a: assert property (timer_irq |-> en_reg || $past(en_reg))
    else $error("interrupt while disabled");
  lvl_reset_a: assert property (mode_reg == MODE_LVL_HIGH && on_reg && hi_cnt == 4'hF
    |-> timer_count == 8'h00)
    else $error("count not held at zero at reset level");
  gate_hold_a: assert property (mode_reg == MODE_GATE_HIGH && lo_cnt == 4'hF
    && !req.wr && !debug_freeze |=> $stable(timer_count))
    else $error("count moved with gate closed");
  cover property (postscaled_match_pulse);
  cover property (timer_irq);
  cover property (mode_reg == MODE_MS_RISE && period_match);
endmodule : hlt_monitor

bind hardware_limit_timer hlt_monitor mon (.clk, .resetn, .req, .rdata, .ext_reset_input,
  .debug_freeze, .postscaled_match_pulse, .timer_irq, .timer_count, .period_match);

// ==== testbench/ext_source.sv ====
// external reset source model feeding the timer
`timescale 1ns/10ps
module ext_source (
  // clock
  input  wire logic clk,
  // external reset line
  output logic      ext_reset_input
);
  initial ext_reset_input = 1'b0;
  // quiet tail keeps triggers apart whatever the caller does next
  task pulse(input int w);
    @(posedge clk);
    ext_reset_input <= 1'b1;
    repeat (w) @(posedge clk);
    ext_reset_input <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask : pulse
  task level(input logic l);
    @(posedge clk);
    ext_reset_input <= l;
    repeat (3) @(posedge clk);
    #1;
  endtask : level
endmodule : ext_source

// ==== testbench/hardware_limit_timer_test.sv ====
// self-checking bench for the hardware limit timer
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module hardware_limit_timer_test;
  import hlt_pkg::*;
  logic       clk;
  logic       resetn;
  reg_req_t   req;
  logic       debug_freeze;
  wire logic  ext_sig;
  logic [7:0] rdata;
  logic       post_pulse;
  logic       timer_irq;
  logic [7:0] timer_count;
  logic       period_match;
  logic [7:0] v;
  int         miscompares;
  int         checked;
  hardware_limit_timer dut (.clk, .resetn, .req, .rdata, .ext_reset_input(ext_sig),
    .debug_freeze, .postscaled_match_pulse(post_pulse), .timer_irq, .timer_count,
    .period_match);
  ext_source src (.clk, .ext_reset_input(ext_sig));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 v = rdata;
  endtask : rd
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wait_match;
    int i;
    cyc(1);
    for (i = 0; i < 600 && period_match !== 1'b1; i++)
      cyc(1);
    if (i == 600)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_match
  task start(input logic [4:0] m, input logic [7:0] p, input logic [3:0] ps);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, {3'h0, m});
    wr(ADDR_PERIOD, p);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL, {1'b1, 3'h0, ps});
  endtask : start
  task t_regs;
    rd(ADDR_PERIOD);
    `CHK(v, PERIOD_RESET)
    rd(ADDR_MODE);
    `CHK(v, {3'h0, MODE_RESET})
    rd(ADDR_CONTROL);
    `CHK(v, 8'h00)
    wr(4'hF, 8'h5A);
    rd(4'hF);
    `CHK(v, 8'h00)
    $display("test regs done");
  endtask : t_regs
  task t_free;
    int i;
    wr(ADDR_IRQ_CTRL, 8'h01);
    start(MODE_SW_GATE, 8'h03, 4'h0);
    wait_match();
    for (i = 1; i < 4; i++)
    begin
      cyc(1);
      `CHK(timer_count, i[7:0])
    end
    cyc(1);
    `CHK({period_match, timer_count}, 9'h100)
    cyc(2);
    `CHK(timer_irq, 1'b1)
    wr(ADDR_IRQ_CTRL, 8'h02);
    cyc(2);
    `CHK(timer_irq, 1'b0)
    wr(ADDR_CONTROL, 8'h00);
    cyc(3);
    v = timer_count;
    cyc(6);
    `CHK(timer_count, v)
    start(MODE_SW_GATE, 8'hFF, 4'h0);
    wr(ADDR_CONTROL, 8'hA0);
    cyc(1);
    v = timer_count;
    cyc(40);
    `CHK(timer_count, v + 8'h0A)
    wr(ADDR_IRQ_CTRL, 8'h00);
    $display("test free run done");
  endtask : t_free
  task t_post;
    int n;
    int i;
    start(MODE_SW_GATE, 8'h02, 4'h2);
    n = 0;
    for (i = 0; i < 100 && post_pulse !== 1'b1; i++)
    begin
      cyc(1);
      if (period_match === 1'b1)
        n++;
    end
    `CHK(n, 3)
    $display("test postscaler done");
  endtask : t_post
  task t_shots;
    start(MODE_OS_SW, 8'h04, 4'h0);
    wait_match();
    cyc(4);
    `CHK(timer_count, 8'h00)
    rd(ADDR_CONTROL);
    `CHK(v[7], 1'b0)
    start(MODE_MS_RISE, 8'h10, 4'h0);
    cyc(10);
    `CHK(timer_count, 8'h00)
    src.pulse(6);
    wait_match();
    cyc(4);
    `CHK(timer_count, 8'h00)
    rd(ADDR_CONTROL);
    `CHK(v[7], 1'b1)
    start(MODE_OS_HL_RISE, 8'h30, 4'h0);
    cyc(10);
    `CHK(timer_count, 8'h00)
    src.pulse(6);
    cyc(10);
    src.pulse(6);
    `CHK(timer_count < 8'h08, 1'b1)
    wait_match();
    rd(ADDR_CONTROL);
    `CHK(v[7], 1'b0)
    wr(ADDR_CONTROL, 8'h80);
    cyc(10);
    `CHK(timer_count, 8'h00)
    $display("test one-shot and monostable done");
  endtask : t_shots
  task t_levels;
    start(MODE_LVL_HIGH, 8'hFF, 4'h0);
    cyc(10);
    src.level(1'b1);
    cyc(20);
    `CHK(timer_count, 8'h00)
    src.level(1'b0);
    cyc(10);
    `CHK(timer_count !== 8'h00, 1'b1)
    start(MODE_GATE_HIGH, 8'hFF, 4'h0);
    cyc(20);
    `CHK(timer_count, 8'h00)
    src.level(1'b1);
    cyc(10);
    `CHK(timer_count !== 8'h00, 1'b1)
    src.level(1'b0);
    start(MODE_GATE_LOW, 8'hFF, 4'h0);
    cyc(10);
    src.level(1'b1);
    cyc(2);
    v = timer_count;
    cyc(10);
    `CHK(timer_count, v)
    `CHK(v !== 8'h00, 1'b1)
    src.level(1'b0);
    start(MODE_LOS_LOW, 8'hFF, 4'h0);
    cyc(10);
    `CHK(timer_count, 8'h00)
    src.level(1'b1);
    cyc(10);
    `CHK(timer_count !== 8'h00, 1'b1)
    $display("test level modes done");
  endtask : t_levels
  task t_edge;
    src.level(1'b0);
    start(MODE_EDGE_RISE, 8'hFF, 4'h0);
    cyc(30);
    src.pulse(6);
    `CHK(timer_count < 8'h10, 1'b1)
    @(posedge clk) debug_freeze <= 1'b1;
    cyc(20);
    src.pulse(6);
    `CHK(timer_count > 8'h14, 1'b1)
    @(posedge clk) debug_freeze <= 1'b0;
    start(MODE_EDGE_ANY, 8'hFF, 4'h0);
    cyc(30);
    src.level(1'b1);
    cyc(4);
    `CHK(timer_count < 8'h04, 1'b1)
    cyc(20);
    src.level(1'b0);
    cyc(4);
    `CHK(timer_count < 8'h04, 1'b1)
    $display("test edge reset done");
  endtask : t_edge
  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial
  begin
    req = '0;
    debug_freeze = 1'b0;
    resetn = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_free();
    t_post();
    t_shots();
    t_levels();
    t_edge();
    end_of_test();
  end
endmodule : hardware_limit_timer_test
